/* File: include/acw_pkg.sv */
// Shared constants and types for the acyclic request/response block
package acw_pkg;
  // ****************************************************************
  // Address map (byte addresses, 12-bit bus address)
  // ****************************************************************
  localparam int          ADDR_W       = 12;            // Bus address width
  localparam int          IDX_W        = 7;             // 128 words per area
  localparam logic [2:0]  AREA_REQ     = 3'h0;          // 0x000..0x1FC request area
  localparam logic [2:0]  AREA_RSP     = 3'h1;          // 0x200..0x3FC response area
  localparam logic [11:0] REG_CTRL     = 12'h400;       // Start strobe
  localparam logic [11:0] REG_STATUS   = 12'h404;       // Busy, failed, last code
  localparam logic [11:0] REG_INT_ST   = 12'h408;       // Sticky events, write 1 clears
  localparam logic [11:0] REG_INT_MSK  = 12'h40C;       // Interrupt enables
  localparam logic [1:0]  REGION_REQ   = 2'h0;
  localparam logic [1:0]  REGION_RSP   = 2'h1;
  localparam logic [1:0]  REGION_REG   = 2'h2;
  localparam logic [1:0]  REGION_NONE  = 2'h3;
  localparam int          START_BIT    = 0;             // CTRL bit
  localparam int          EV_OK        = 0;             // Event bit: completed normally
  localparam int          EV_FAIL      = 1;             // Event bit: completed with error
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // ****************************************************************
  // Word formats
  // ****************************************************************
  localparam logic [15:0] CODE_INITIATE = 16'h1412;     // Class-2 initiate request
  localparam logic [15:0] RSP_WRITE1    = 16'hA401;
  localparam logic [15:0] RSP_WRITE2    = 16'hA411;
  localparam logic [15:0] RSP_INITIATE  = 16'hA412;
  localparam logic [15:0] ERR_DETAILED  = 16'hE443;     // Error that carries details
  localparam logic [15:0] NO_DETAIL     = 16'hFFFF;
  localparam logic [15:0] EMPTY_WORD    = 16'h0000;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [6:0]  IDX_CODE      = 7'h00;
  localparam logic [6:0]  IDX_ADDR      = 7'h01;
  localparam logic [6:0]  IDX_DET_LAST  = 7'h04;
  localparam logic [6:0]  IDX_LAST      = 7'h7F;
  localparam logic [2:0]  FETCH_LAST    = 3'h5;         // Words 0..4 plus read latency
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FETCH  = 3'b001,
    ST_DECODE = 3'b010,
    ST_RELAY  = 3'b011,
    ST_FILL   = 3'b100,
    ST_DONE   = 3'b101
  } acw_state_e;
  typedef enum logic [1:0] {
    SVC_WRITE1 = 2'b00,
    SVC_WRITE2 = 2'b01,
    SVC_INIT   = 2'b10,
    SVC_BAD    = 2'b11
  } acw_svc_e;
endpackage : acw_pkg

/* File: include/acw_mem_if.sv */
// Port bundle between the block and one 128-word area memory
`timescale 1ns/1ns
interface acw_mem_if #(parameter int AW = 7, parameter int DW = 16);
  logic          we;     // Write strobe
  logic [1:0]    be;     // Byte enables
  logic [AW-1:0] waddr;  // Write word index
  logic [DW-1:0] wdata;  // Write data
  logic [AW-1:0] raddr;  // Read word index
  logic [DW-1:0] rdata;  // Registered read data
  modport owner (output we, be, waddr, wdata, raddr, input rdata);
  modport mem   (input we, be, waddr, wdata, raddr, output rdata);
endinterface : acw_mem_if

/* File: design/acw_area_mem.sv */
// One word-addressed area memory with byte writes and registered read
`timescale 1ns/1ns
module acw_area_mem #(
  parameter int AW = 7,
  parameter int DW = 16
) (
  input wire logic aclk,
  acw_mem_if.mem   port
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [DW-1:0] cells [0:(1<<AW)-1];  // No reset: contents are software's

  // One writer for the array: lanes share one process
  always_ff @(posedge aclk) begin
    for (int b = 0; b < DW/8; b++) begin
      if (port.we && port.be[b]) cells[port.waddr][b*8 +: 8] <= port.wdata[b*8 +: 8];
    end
  end

  // Read data one cycle after the index
  always_ff @(posedge aclk) begin
    port.rdata <= cells[port.raddr];
  end
endmodule : acw_area_mem

/* File: design/acw_top.sv */
// Acyclic request decoder and response writer behind an AXI4-Lite slave
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// What this block does
// - Failed write puts error code in word 0
// - Class-1 failure word 1: address, zero high
// - Class-2 failure word 1: reference high, address low
// - Error E443 stores detail codes in words 2-4
// - Other errors fill words 2-4 with FFFF
// - Failed response words 5 to 127 are zero
module acw_top #(
  parameter logic [15:0] WR1_REQ_CODE = 16'h1401,   // Class-1 write request code
  parameter logic [15:0] WR2_REQ_CODE = 16'h1411,   // Class-2 write request code
  parameter logic [15:0] ERR_BAD_CODE = 16'hE001    // Error for unknown request code
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             link_req,
  output logic [15:0]      link_service,
  output logic [7:0]       link_slave_addr,
  input  wire logic        link_done,
  input  wire logic        link_fail,
  input  wire logic [15:0] link_err_code,
  input  wire logic [15:0] link_detail1,
  input  wire logic [15:0] link_detail2,
  input  wire logic [15:0] link_detail3,
  input  wire logic [7:0]  link_conn_ref
);
  // ****************************************************************
  // Address decode, shared by read and write paths
  // ****************************************************************
  function automatic logic [1:0] region_of(input logic [11:0] a);
    if (a[11:9] == acw_pkg::AREA_REQ) region_of = acw_pkg::REGION_REQ;
    else if (a[11:9] == acw_pkg::AREA_RSP) region_of = acw_pkg::REGION_RSP;
    else if (a[11:2] == acw_pkg::REG_CTRL[11:2] || a[11:2] == acw_pkg::REG_STATUS[11:2] ||
             a[11:2] == acw_pkg::REG_INT_ST[11:2] || a[11:2] == acw_pkg::REG_INT_MSK[11:2])
      region_of = acw_pkg::REGION_REG;
    else region_of = acw_pkg::REGION_NONE;
  endfunction : region_of

  acw_mem_if req_if ();  // Request area, written by software
  acw_mem_if rsp_if ();  // Response area, written by the sequencer

  acw_area_mem u_req_mem (.aclk(aclk), .port(req_if.mem));
  acw_area_mem u_rsp_mem (.aclk(aclk), .port(rsp_if.mem));

  // ****************************************************************
  // Write channel state
  // ****************************************************************
  logic        aw_full, next_aw_full;    // Address held
  logic [11:0] aw_addr, next_aw_addr;
  logic        w_full, next_w_full;      // Data held
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_awready, next_wready, next_bvalid;
  logic [1:0]  next_bresp;
  logic        do_write;                 // Both halves present, response free

  // Address and data taken in either order, applied together
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    do_write     = aw_full && w_full && !s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      // Unmapped space: error, nothing stored
      next_bresp   = (region_of(aw_addr) == acw_pkg::REGION_NONE) ?
                     acw_pkg::RESP_SLVERR : acw_pkg::RESP_OKAY;
    end
    // One write in flight keeps the slave simple
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      aw_addr       <= '0;
      w_full        <= 1'b0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= acw_pkg::RESP_OKAY;
    end else begin
      aw_full       <= next_aw_full;
      aw_addr       <= next_aw_addr;
      w_full        <= next_w_full;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
    end
  end

  // Only the request area takes software writes
  assign req_if.we    = do_write && region_of(aw_addr) == acw_pkg::REGION_REQ;
  assign req_if.be    = w_strb[1:0];
  assign req_if.waddr = aw_addr[8:2];
  assign req_if.wdata = w_data[15:0];

  // ****************************************************************
  // Sequencer and control registers
  // ****************************************************************
  acw_pkg::acw_state_e state, next_state;
  acw_pkg::acw_svc_e   svc, next_svc;
  logic [2:0]  fetch_cnt, next_fetch_cnt;  // Request word being fetched
  logic [15:0] rq [0:4];                   // Request words 0..4
  logic [15:0] next_rq [0:4];
  logic [15:0] det [2:4];                  // Detail codes by response word
  logic [15:0] next_det [2:4];
  logic        failed, next_failed;        // Outcome of the last request
  logic [15:0] err, next_err;
  logic [7:0]  conn_ref, next_conn_ref;    // connection_reference_number
  logic [6:0]  fill_idx, next_fill_idx;
  logic [1:0]  int_st, next_int_st, int_msk, next_int_msk;
  logic        next_irq, next_link_req;
  logic [15:0] next_link_service;
  logic [7:0]  next_link_slave_addr;
  logic [15:0] rsp_word;                   // Response word at fill_idx
  logic [15:0] ok_code;
  logic        start;

  // Response word builder
  always_comb begin
    unique case (svc)
      acw_pkg::SVC_WRITE1: ok_code = acw_pkg::RSP_WRITE1;
      acw_pkg::SVC_WRITE2: ok_code = acw_pkg::RSP_WRITE2;
      acw_pkg::SVC_INIT:   ok_code = acw_pkg::RSP_INITIATE;
      acw_pkg::SVC_BAD:    ok_code = acw_pkg::EMPTY_WORD;
    endcase
    if (fill_idx == acw_pkg::IDX_CODE) begin
      rsp_word = failed ? err : ok_code;
    end else if (fill_idx == acw_pkg::IDX_ADDR) begin
      if (svc == acw_pkg::SVC_WRITE1) rsp_word = {acw_pkg::ZERO_BYTE, rq[1][7:0]};
      else rsp_word = {conn_ref, rq[1][7:0]};
    end else if (fill_idx <= acw_pkg::IDX_DET_LAST) begin
      if (!failed) begin
        rsp_word = (svc == acw_pkg::SVC_INIT) ? acw_pkg::EMPTY_WORD : rq[fill_idx[2:0]];
      end else if (err == acw_pkg::ERR_DETAILED) begin
        rsp_word = det[fill_idx[2:0]];
      end else begin
        rsp_word = acw_pkg::NO_DETAIL;
      end
    end else begin
      rsp_word = acw_pkg::EMPTY_WORD;
    end
  end

  // Next state of the sequencer and of the software-visible bits
  always_comb begin
    next_state           = state;
    next_svc             = svc;
    next_fetch_cnt       = fetch_cnt;
    next_rq              = rq;
    next_det             = det;
    next_failed          = failed;
    next_err             = err;
    next_conn_ref        = conn_ref;
    next_fill_idx        = fill_idx;
    next_int_msk         = int_msk;
    next_int_st          = int_st;
    next_link_req        = link_req;
    next_link_service    = link_service;
    next_link_slave_addr = link_slave_addr;
    rsp_if.we            = 1'b0;
    rsp_if.be            = 2'b11;
    rsp_if.waddr         = fill_idx;
    rsp_if.wdata         = rsp_word;
    start = do_write && aw_addr[11:2] == acw_pkg::REG_CTRL[11:2] &&
            w_strb[0] && w_data[acw_pkg::START_BIT];
    // Register writes: mask stores, event bits clear on one
    if (do_write && aw_addr[11:2] == acw_pkg::REG_INT_MSK[11:2] && w_strb[0])
      next_int_msk = w_data[1:0];
    if (do_write && aw_addr[11:2] == acw_pkg::REG_INT_ST[11:2] && w_strb[0])
      next_int_st = int_st & ~w_data[1:0];
    unique case (state)
      acw_pkg::ST_IDLE: begin
        // Start while busy is dropped, so requests never overlap
        if (start) begin
          next_state     = acw_pkg::ST_FETCH;
          next_fetch_cnt = '0;
        end
      end
      acw_pkg::ST_FETCH: begin
        // Read data lag the index by one cycle
        next_fetch_cnt = fetch_cnt + 3'h1;
        if (fetch_cnt != '0) next_rq[fetch_cnt - 3'h1] = req_if.rdata;
        if (fetch_cnt == acw_pkg::FETCH_LAST) next_state = acw_pkg::ST_DECODE;
      end
      acw_pkg::ST_DECODE: begin
        // Select the service from word 0
        if (rq[0] == WR1_REQ_CODE) next_svc = acw_pkg::SVC_WRITE1;
        else if (rq[0] == WR2_REQ_CODE) next_svc = acw_pkg::SVC_WRITE2;
        else if (rq[0] == acw_pkg::CODE_INITIATE) next_svc = acw_pkg::SVC_INIT;
        else next_svc = acw_pkg::SVC_BAD;
        if (next_svc == acw_pkg::SVC_BAD) begin
          // Unknown code fails without the link
          next_failed   = 1'b1;
          next_err      = ERR_BAD_CODE;
          next_conn_ref = acw_pkg::ZERO_BYTE;
          next_fill_idx = '0;
          next_state    = acw_pkg::ST_FILL;
        end else begin
          next_link_req        = 1'b1;
          next_link_service    = rq[0];
          next_link_slave_addr = rq[1][7:0];
          next_state           = acw_pkg::ST_RELAY;
        end
      end
      acw_pkg::ST_RELAY: begin
        // Hold the relay until the link answers
        if (link_done) begin
          next_link_req = 1'b0;
          next_failed   = link_fail;
          next_err      = link_err_code;
          next_det[2]   = link_detail1;
          next_det[3]   = link_detail2;
          next_det[4]   = link_detail3;
          next_conn_ref = (svc == acw_pkg::SVC_INIT) ? link_conn_ref : rq[1][15:8];
          next_fill_idx = '0;
          next_state    = acw_pkg::ST_FILL;
        end
      end
      acw_pkg::ST_FILL: begin
        // One layout, success or failure, all words
        rsp_if.we     = 1'b1;
        next_fill_idx = fill_idx + 7'h01;
        if (fill_idx == acw_pkg::IDX_LAST) next_state = acw_pkg::ST_DONE;
      end
      acw_pkg::ST_DONE: begin
        // Set after the clear: set wins
        next_int_st[failed ? acw_pkg::EV_FAIL : acw_pkg::EV_OK] = 1'b1;
        next_state = acw_pkg::ST_IDLE;
      end
      default: next_state = acw_pkg::ST_IDLE;
    endcase
    next_irq = |(next_int_st & next_int_msk);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state           <= acw_pkg::ST_IDLE;
      svc             <= acw_pkg::SVC_BAD;
      fetch_cnt       <= '0;
      for (int i = 0; i <= 4; i++) rq[i] <= '0;
      for (int i = 2; i <= 4; i++) det[i] <= '0;
      failed          <= 1'b0;
      err             <= '0;
      conn_ref        <= '0;
      fill_idx        <= '0;
      int_st          <= '0;
      int_msk         <= '0;
      irq             <= 1'b0;
      link_req        <= 1'b0;
      link_service    <= '0;
      link_slave_addr <= '0;
    end else begin
      state           <= next_state;
      svc             <= next_svc;
      fetch_cnt       <= next_fetch_cnt;
      rq              <= next_rq;
      det             <= next_det;
      failed          <= next_failed;
      err             <= next_err;
      conn_ref        <= next_conn_ref;
      fill_idx        <= next_fill_idx;
      int_st          <= next_int_st;
      int_msk         <= next_int_msk;
      irq             <= next_irq;
      link_req        <= next_link_req;
      link_service    <= next_link_service;
      link_slave_addr <= next_link_slave_addr;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic        ar_pend, next_ar_pend;   // Address waiting for the memory port
  logic        rd_wait, next_rd_wait;   // Memory data arriving
  logic [11:0] ar_addr, next_ar_addr;
  logic        next_arready, next_rvalid, fetching;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Fetch owns the request port; request-area reads wait
  assign fetching     = state == acw_pkg::ST_FETCH;
  assign req_if.raddr = fetching ? 7'(fetch_cnt) : ar_addr[8:2];
  assign rsp_if.raddr = ar_addr[8:2];

  always_comb begin
    next_ar_pend = ar_pend;
    next_ar_addr = ar_addr;
    next_rd_wait = 1'b0;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_ar_pend = 1'b1;
      next_ar_addr = s_axi_araddr;
    end
    if (ar_pend && !(fetching && region_of(ar_addr) == acw_pkg::REGION_REQ)) begin
      next_ar_pend = 1'b0;
      next_rd_wait = 1'b1;
    end
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (rd_wait) begin
      next_rvalid = 1'b1;
      next_rresp  = acw_pkg::RESP_OKAY;
      unique case (region_of(ar_addr))
        acw_pkg::REGION_REQ: next_rdata = {16'h0000, req_if.rdata};
        acw_pkg::REGION_RSP: next_rdata = {16'h0000, rsp_if.rdata};
        acw_pkg::REGION_REG: begin
          if (ar_addr[11:2] == acw_pkg::REG_STATUS[11:2])
            next_rdata = {err, 14'h0000, failed, state != acw_pkg::ST_IDLE};
          else if (ar_addr[11:2] == acw_pkg::REG_INT_ST[11:2])
            next_rdata = {30'h00000000, int_st};
          else if (ar_addr[11:2] == acw_pkg::REG_INT_MSK[11:2])
            next_rdata = {30'h00000000, int_msk};
          else next_rdata = 32'h00000000;   // Start strobe reads as zero
        end
        acw_pkg::REGION_NONE: begin
          next_rdata = 32'h00000000;
          next_rresp = acw_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_ar_pend && !next_rd_wait && !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_pend       <= 1'b0;
      rd_wait       <= 1'b0;
      ar_addr       <= '0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= acw_pkg::RESP_OKAY;
    end else begin
      ar_pend       <= next_ar_pend;
      rd_wait       <= next_rd_wait;
      ar_addr       <= next_ar_addr;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end
endmodule : acw_top

/* File: tb/acw_top_props.sv */
// Checker: response layout and link hand-off seen at the top ports
`timescale 1ns/1ns
module acw_top_props #(
  parameter logic [15:0] WR1_REQ_CODE = 16'h1401,
  parameter logic [15:0] WR2_REQ_CODE = 16'h1411
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        link_req,
  input wire logic [15:0] link_service,
  input wire logic [7:0]  link_slave_addr,
  input wire logic        link_done,
  input wire logic        link_fail,
  input wire logic [15:0] link_err_code,
  input wire logic [15:0] link_detail1
);
  logic [11:0] ar_q;            // Read in flight
  logic [15:0] err_q;           // Last link error code
  logic [15:0] det_q;           // Last detail 1
  logic [15:0] svc_q;           // Last relayed service
  logic [7:0]  adr_q;           // Last relayed slave address
  logic        fl_q;            // Last link run failed
  // Capture link results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fl_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 12'h400) begin
      fl_q <= 1'b0;
    end else if (link_req && link_done) begin
      fl_q  <= link_fail;
      err_q <= link_err_code;
      det_q <= link_detail1;
      svc_q <= link_service;
      adr_q <= link_slave_addr;
    end
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_err_word;
    s_axi_rvalid && fl_q && ar_q == 12'h200 |-> s_axi_rdata[15:0] == err_q;
  endproperty
  a_err_word: assert property (p_err_word) else $error("error code word wrong");
  property p_c1_addr;
    s_axi_rvalid && fl_q && svc_q == WR1_REQ_CODE && ar_q == 12'h204
      |-> s_axi_rdata[15:0] == {8'h00, adr_q};
  endproperty
  a_c1_addr: assert property (p_c1_addr) else $error("class 1 address word wrong");
  property p_c2_addr;
    s_axi_rvalid && fl_q && svc_q == WR2_REQ_CODE && ar_q == 12'h204
      |-> s_axi_rdata[7:0] == adr_q;
  endproperty
  a_c2_addr: assert property (p_c2_addr) else $error("class 2 address byte wrong");
  property p_detail;
    s_axi_rvalid && fl_q && err_q == 16'hE443 && ar_q == 12'h208
      |-> s_axi_rdata[15:0] == det_q;
  endproperty
  a_detail: assert property (p_detail) else $error("detail code wrong");
  property p_no_detail;
    s_axi_rvalid && fl_q && err_q != 16'hE443 && ar_q inside {12'h208, 12'h20C, 12'h210}
      |-> s_axi_rdata[15:0] == 16'hFFFF;
  endproperty
  a_no_detail: assert property (p_no_detail) else $error("missing no-detail mark");
  property p_empty;
    s_axi_rvalid && ar_q >= 12'h214 && ar_q < 12'h400 |-> s_axi_rdata == 32'h0;
  endproperty
  a_empty: assert property (p_empty) else $error("empty response word not zero");
  property p_hold;
    link_req && !link_done |=> link_req && $stable(link_service);
  endproperty
  a_hold: assert property (p_hold) else $error("relay dropped early");
  property p_drop;
    link_req && link_done |=> !link_req;
  endproperty
  a_drop: assert property (p_drop) else $error("relay held after done");
  cover property (link_req && link_done && link_fail);
  cover property (link_req && link_done && !link_fail);
  cover property (s_axi_rvalid && fl_q && ar_q == 12'h208);
endmodule : acw_top_props
bind acw_top acw_top_props #(
  .WR1_REQ_CODE(WR1_REQ_CODE),
  .WR2_REQ_CODE(WR2_REQ_CODE)
) u_props (.*);

/* File: tb/acw_link_model.sv */
// Far-side station: answers each relayed request after a set latency
`timescale 1ns/1ns
module acw_link_model (
  input  wire logic        aclk,
  input  wire logic        link_req,
  input  wire logic        fail_in,
  input  wire logic [15:0] err_in,
  input  wire logic [3:0]  lat,
  output logic             link_done,
  output logic             link_fail,
  output logic [15:0]      link_err_code,
  output logic [15:0]      link_detail1,
  output logic [15:0]      link_detail2,
  output logic [15:0]      link_detail3,
  output logic [7:0]       link_conn_ref
);
  logic [3:0] cnt = 4'h0;  // Cycles waited on this request
  initial link_done = 1'b0;
  // One-cycle done pulse after lat cycles
  always @(posedge aclk) begin
    link_done <= link_req && !link_done && cnt == lat;
    cnt       <= (link_req && !link_done && cnt != lat) ? cnt + 4'h1 : 4'h0;
  end
  // Inverse outside the pulse, so stale values fail
  assign link_fail     = link_done ? fail_in : !fail_in;
  assign link_err_code = link_done ? err_in : ~err_in;
  assign link_detail1  = link_done ? 16'h0D11 : 16'hF2EE;
  assign link_detail2  = link_done ? 16'h0D22 : 16'hF2DD;
  assign link_detail3  = link_done ? 16'h0D33 : 16'hF2CC;
  assign link_conn_ref = link_done ? 8'h2A : 8'hD5;
endmodule : acw_link_model

/* File: tb/testbench.sv */
// Bench: host program issuing requests over the register bus
`timescale 1ns/1ns
module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0, fail_in = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;  // Answers always taken
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, rdat, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, lat = 4'h0;
  logic [15:0] err_in = 16'h0, svc_seen = 16'h0, link_service, link_err_code;
  logic [15:0] link_detail1, link_detail2, link_detail3;
  logic [1:0]  rrsp, s_axi_bresp, s_axi_rresp;
  logic [7:0]  link_slave_addr, link_conn_ref;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        irq, link_req, link_done, link_fail;
  int          n_mismatch = 0, total_checks = 0, n_req = 0;
  acw_top u_acw_top (.*);
  acw_link_model u_acw_link_model (.*);
  always #50 aclk = ~aclk;  // 10 MHz
  // Link log
  always @(posedge aclk) begin
    if (link_req) svc_seen <= link_service;
    if (link_req && link_done) n_req <= n_req + 1;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Write: both halves offered, each freed when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rrsp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
  endtask : rd
  // Load, start, poll till idle; words 5-7 zero
  task automatic run(input logic [15:0] w [5]);
    for (int i = 0; i < 8; i++) wr(12'(4 * i), {16'h0, (i < 5) ? w[i] : 16'h0});
    wr(12'h400, 32'h1);
    do rd(12'h404); while (rdat[0] !== 1'b0);
  endtask : run
  task automatic rsp(input logic [15:0] e [5]);
    for (int i = 0; i < 5; i++) begin
      rd(12'h200 + 12'(4 * i));
      chk(rdat, {16'h0, e[i]});
    end
    for (int i = 5; i < 128; i += 61) begin
      rd(12'h200 + 12'(4 * i));
      chk(rdat, 32'h0);
    end
    $display("Test done at %0t", $time);
  endtask : rsp
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // Watchdog, 20000 cycles
  initial begin
    #2000000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(12'h40C, 32'h2);  // Only failures raise irq
    fail_in <= 1'b1;
    err_in  <= 16'hE443;
    run('{16'h1401, 16'h007D, 16'h00F0, 16'h00FE, 16'h00FF});
    rsp('{16'hE443, 16'h007D, 16'h0D11, 16'h0D22, 16'h0D33});
    err_in  <= 16'hE100;
    lat     <= 4'h3;
    run('{16'h1411, 16'h7E05, 16'h0001, 16'h0000, 16'h0000});
    rsp('{16'hE100, 16'h7E05, 16'hFFFF, 16'hFFFF, 16'hFFFF});
    run('{16'h1234, 16'h0005, 16'h0001, 16'h0, 16'h0});
    rsp('{16'hE001, 16'h0005, 16'hFFFF, 16'hFFFF, 16'hFFFF});
    chk(n_req, 2);
    fail_in <= 1'b0;
    lat     <= 4'hF;
    // Initiate, longest latency
    run('{16'h1412, 16'h007D, 16'hFFFF, 16'h0, 16'h0001});
    rsp('{16'hA412, 16'h2A7D, 16'h0, 16'h0, 16'h0});
    chk({16'h0, svc_seen}, 32'h1412);
    rd(12'h408);
    chk(rdat, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(12'h408, 32'h3);
    rd(12'h408);
    chk(rdat, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(12'h500);
    chk({30'h0, rrsp}, 32'h2);
    chk(rdat, 32'h0);
    wr(12'h500, 32'h0);
    chk({30'h0, rrsp}, 32'h2);
    end_of_test;
  end
endmodule : testbench
